// *** sdrl_pkg.sv ***
package sdrl_pkg;

   // Clock and control tick
   localparam int unsigned CLK_HZ        = 250_000_000;
   localparam int unsigned TICK_MS       = 1;
   localparam int unsigned TICK_CYC_DEF  = CLK_HZ / 1000 * TICK_MS;

   // Register word indices on the Avalon address
   localparam int unsigned NCFG          = 12;
   localparam logic [3:0]  ADDR_METHOD    = 4'h0;
   localparam logic [3:0]  ADDR_UP_SHAPE  = 4'h1;
   localparam logic [3:0]  ADDR_DN_SHAPE  = 4'h2;
   localparam logic [3:0]  ADDR_UP_TIME   = 4'h3;
   localparam logic [3:0]  ADDR_SLOW_TIME = 4'h4;
   localparam logic [3:0]  ADDR_FAST_THR  = 4'h5;
   localparam logic [3:0]  ADDR_FAST_TIME = 4'h6;
   localparam logic [3:0]  ADDR_ABORT_THR = 4'h7;
   localparam logic [3:0]  ADDR_ABORT_TIM = 4'h8;
   localparam logic [3:0]  ADDR_UP_TIME_HS = 4'h9;
   localparam logic [3:0]  ADDR_SLOW_TM_HS = 4'ha;
   localparam logic [3:0]  ADDR_SPEED_LIM = 4'hb;
   localparam logic [3:0]  ADDR_FLOW_STAT = 4'hc;
   localparam logic [3:0]  ADDR_RAMP_STAT = 4'hd;

   // Values after reset, in index order 11 down to 0
   localparam logic [NCFG-1:0][15:0] CFG_RESET = {
      16'h01f4, 16'h015e, 16'h00c8, 16'h0001, 16'h0000, 16'h0064,
      16'h03e8, 16'h015e, 16'h0001, 16'h0000, 16'h0000, 16'h0000};

   // Ramp methods
   localparam logic [15:0] METHOD_OFF    = 16'h0000;
   localparam logic [15:0] METHOD_FIXED  = 16'h0001;
   localparam logic [15:0] METHOD_SPEED  = 16'h0002;

   // Flow scale, 1 unit = 0.1 % of maximum port flow
   localparam logic [15:0] FLOW_MAX      = 16'h03e8;
   localparam logic [31:0] FULL_SCALE_Q8 = 32'h0003e800;
   localparam logic [3:0]  SHAPE_MAX     = 4'ha;

   // Progressive curve breakpoints and segment slopes (Q8) at full shape
   localparam logic [9:0]  BRK_1         = 10'h032;
   localparam logic [9:0]  BRK_2         = 10'h078;
   localparam logic [9:0]  BRK_3         = 10'h14d;
   localparam int          SLOPE_SEG0    = 32'h033;
   localparam int          SLOPE_SEG1    = 32'h048;
   localparam int          SLOPE_SEG2    = 32'h0da;
   localparam int          SLOPE_SEG3    = 32'h2ab;
   localparam int          SLOPE_UNITY   = 32'h100;
   localparam int          TENTH_Q8      = 32'h01a;

   // Divider length
   localparam logic [5:0]  DIV_LAST      = 6'h1f;

   typedef enum logic [1:0] {PH_IDLE, PH_INTERP, PH_STEP, PH_APPLY} sdrl_phase_e;

endpackage : sdrl_pkg

// *** sdrl_div.sv ***
module sdrl_div
   import sdrl_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        start_i,
   input  wire logic [31:0] dividend_i,
   input  wire logic [15:0] divisor_i,
   output logic      [31:0] quotient_o,
   output logic             done_o
);

   typedef struct packed {
      logic        busy;
      logic [5:0]  cnt;
      logic [16:0] rem;
      logic [31:0] quo;
      logic [15:0] den;
      logic        done;
   } sdrl_div_s;

   sdrl_div_s s_reg;
   sdrl_div_s s_next;

   // Restoring division, one quotient bit per clock
   always_comb begin
      logic [16:0] shifted;
      shifted = 17'h00000;
      s_next = s_reg;
      s_next.done = 1'b0;
      if (start_i) begin
         s_next.busy = 1'b1;
         s_next.cnt  = 6'h00;
         s_next.rem  = 17'h00000;
         s_next.quo  = dividend_i;
         s_next.den  = divisor_i;
      end else if (s_reg.busy) begin
         shifted = {s_reg.rem[15:0], s_reg.quo[31]};
         s_next.quo = {s_reg.quo[30:0], 1'b0};
         if (shifted >= {1'b0, s_reg.den}) begin
            s_next.rem    = shifted - {1'b0, s_reg.den};
            s_next.quo[0] = 1'b1;
         end else begin
            s_next.rem = shifted;
         end
         s_next.cnt = s_reg.cnt + 6'h01;
         if (s_reg.cnt == DIV_LAST) begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign quotient_o = s_reg.quo;
   assign done_o     = s_reg.done;

endmodule : sdrl_div

// *** sdrl_ramp_limiter.sv ***
// Design decisions made here: the Avalon-MM register port and the register offsets.
module sdrl_ramp_limiter
   import sdrl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic [15:0] requested_port_flow_i,
   input  wire logic [15:0] vehicle_speed_i,
   output logic      [15:0] limited_port_flow_o,
   output logic             abort_active_o
);

   typedef struct packed {
      logic                   wait_r;
      logic [31:0]            rdata;
      logic [NCFG-1:0][15:0]  cfg;
      logic [31:0]            tick_cnt;
      sdrl_phase_e            phase;
      logic [17:0]            cur_mag;
      logic                   cur_neg;
      logic                   abort_act;
      logic [17:0]            tgt_mag;
      logic                   going_up;
      logic                   fast_on;
      logic                   interp_neg;
      logic [15:0]            t_base;
      logic [3:0]             shape;
      logic                   div_start;
      logic [31:0]            div_num;
      logic [15:0]            div_den;
      logic [15:0]            out_flow;
   } sdrl_state_s;

   sdrl_state_s s_reg;
   sdrl_state_s s_next;
   logic [1:0]  rst_sync;
   logic        rst_n;
   logic [31:0] div_quo;
   logic        div_done;

   // Reset is released through two flops so the state and divider flops leave reset together
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   sdrl_div u_div (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n),
      .start_i    (s_reg.div_start),
      .dividend_i (s_reg.div_num),
      .divisor_i  (s_reg.div_den),
      .quotient_o (div_quo),
      .done_o     (div_done)
   );

   // Zero times would divide by zero; treat them as the least legal time
   function automatic logic [15:0] sdrl_tsafe(input logic [15:0] t);
      sdrl_tsafe = (t == 16'h0000) ? 16'h0001 : t;
   endfunction : sdrl_tsafe

   always_comb begin
      logic        req_neg;
      logic [15:0] req_abs;
      logic [9:0]  req_mag;
      logic [17:0] req_q8;
      logic [9:0]  cur_int;
      logic        rev;
      logic        up;
      logic        fast;
      logic        abort_now;
      logic        interp;
      logic [15:0] t_hi;
      logic [15:0] diff;
      logic [15:0] spd;
      logic [15:0] lim;
      logic [15:0] t_eff;
      logic [3:0]  shp;
      int          smax;
      int          slope_i;
      int          step_i;
      logic [17:0] step;
      logic [15:0] wval;
      logic [3:0]  idx;

      req_neg   = requested_port_flow_i[15];
      req_abs   = req_neg ? (16'h0000 - requested_port_flow_i) : requested_port_flow_i;
      req_mag   = (req_abs > FLOW_MAX) ? FLOW_MAX[9:0] : req_abs[9:0];
      req_q8    = {req_mag, 8'h00};
      cur_int   = s_reg.cur_mag[17:8];
      rev       = 1'b0;
      up        = 1'b0;
      fast      = 1'b0;
      abort_now = 1'b0;
      interp    = 1'b0;
      t_hi      = 16'h0000;
      diff      = 16'h0000;
      spd       = 16'h0000;
      lim       = s_reg.cfg[ADDR_SPEED_LIM];
      t_eff     = 16'h0000;
      shp       = 4'h0;
      smax      = SLOPE_UNITY;
      slope_i   = SLOPE_UNITY;
      step_i    = 0;
      step      = 18'h00000;
      wval      = 16'h0000;
      idx       = avs_address_i;
      s_next    = s_reg;
      s_next.div_start = 1'b0;

      // Avalon slave: one wait cycle, then waitrequest low for one edge
      if (!s_reg.wait_r) begin
         s_next.wait_r = 1'b1;
      end else if (avs_read_i || avs_write_i) begin
         s_next.wait_r = 1'b0;
         s_next.rdata  = 32'h00000000;
         if (avs_write_i && (32'(idx) < NCFG)) begin
            wval = s_reg.cfg[idx];
            if (avs_byteenable_i[0]) begin
               wval[7:0] = avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
               wval[15:8] = avs_writedata_i[15:8];
            end
            s_next.cfg[idx] = wval;
         end else if (avs_read_i) begin
            if (32'(idx) < NCFG) begin
               s_next.rdata = {16'h0000, s_reg.cfg[idx]};
            end else if (idx == ADDR_FLOW_STAT) begin
               s_next.rdata = {16'h0000, s_reg.out_flow};
            end else if (idx == ADDR_RAMP_STAT) begin
               s_next.rdata = {28'h0000000, s_reg.fast_on, s_reg.going_up,
                               s_reg.cur_neg, s_reg.abort_act};
            end
         end
      end

      // Control tick
      if (s_reg.tick_cnt >= TICK_CYCLES - 1) begin
         s_next.tick_cnt = 32'h00000000;
      end else begin
         s_next.tick_cnt = s_reg.tick_cnt + 32'h00000001;
      end

      if (s_reg.cfg[ADDR_METHOD] != METHOD_FIXED &&
          s_reg.cfg[ADDR_METHOD] != METHOD_SPEED) begin
         // Bypass: follow the request at the next clock edge, with no tick wait
         s_next.cur_mag   = req_q8;
         s_next.cur_neg   = req_neg;
         s_next.abort_act = 1'b0;
         s_next.phase     = PH_IDLE;
      end else begin
         case (s_reg.phase)
            PH_IDLE: begin
               if (s_reg.tick_cnt >= TICK_CYCLES - 1) begin
                  rev = (s_reg.cur_mag != 18'h00000) && (req_mag != 10'h000) &&
                        (req_neg != s_reg.cur_neg);
                  up  = !rev && (req_q8 > s_reg.cur_mag);
                  if (s_reg.cur_mag == 18'h00000) begin
                     s_next.cur_neg = req_neg;
                  end
                  s_next.tgt_mag  = rev ? 18'h00000 : req_q8;
                  s_next.going_up = up;
                  fast = (s_reg.cfg[ADDR_FAST_THR] < FLOW_MAX) &&
                         ({6'h00, cur_int} > s_reg.cfg[ADDR_FAST_THR]);
                  abort_now = rev && !fast &&
                              (s_reg.cfg[ADDR_ABORT_THR] != FLOW_MAX) &&
                              ({6'h00, req_mag} > s_reg.cfg[ADDR_ABORT_THR]);
                  if (up || (s_reg.cur_mag == 18'h00000)) begin
                     s_next.abort_act = 1'b0;
                  end else if (abort_now) begin
                     s_next.abort_act = 1'b1;
                  end
                  s_next.fast_on = !up && fast && !s_reg.abort_act;
                  if (up) begin
                     t_eff = s_reg.cfg[ADDR_UP_TIME];
                     t_hi  = s_reg.cfg[ADDR_UP_TIME_HS];
                     shp   = s_reg.cfg[ADDR_UP_SHAPE][3:0];
                     interp = 1'b1;
                  end else if (s_reg.abort_act || abort_now) begin
                     t_eff = s_reg.cfg[ADDR_ABORT_TIM];
                  end else if (fast) begin
                     t_eff = s_reg.cfg[ADDR_FAST_TIME];
                  end else begin
                     t_eff = s_reg.cfg[ADDR_SLOW_TIME];
                     t_hi  = s_reg.cfg[ADDR_SLOW_TM_HS];
                     shp   = s_reg.cfg[ADDR_DN_SHAPE][3:0];
                     interp = 1'b1;
                  end
                  if (s_reg.cfg[ADDR_DN_SHAPE] > 16'(SHAPE_MAX) && !up) begin
                     shp = SHAPE_MAX;
                  end
                  if (s_reg.cfg[ADDR_UP_SHAPE] > 16'(SHAPE_MAX) && up) begin
                     shp = SHAPE_MAX;
                  end
                  s_next.shape  = shp;
                  s_next.t_base = sdrl_tsafe(t_eff);
                  interp = interp && (s_reg.cfg[ADDR_METHOD] == METHOD_SPEED) &&
                           (lim != 16'h0000);
                  if (interp) begin
                     // Linear blend between zero-speed time and time at the limit
                     spd  = (vehicle_speed_i > lim) ? lim : vehicle_speed_i;
                     s_next.interp_neg = t_hi < t_eff;
                     diff = (t_hi < t_eff) ? (t_eff - t_hi) : (t_hi - t_eff);
                     s_next.div_num   = 32'(diff) * 32'(spd);
                     s_next.div_den   = lim;
                     s_next.div_start = 1'b1;
                     s_next.phase     = PH_INTERP;
                  end else begin
                     s_next.div_num   = FULL_SCALE_Q8;
                     s_next.div_den   = sdrl_tsafe(t_eff);
                     s_next.div_start = 1'b1;
                     s_next.phase     = PH_STEP;
                  end
               end
            end
            PH_INTERP: begin
               if (div_done) begin
                  t_eff = s_reg.interp_neg ? (s_reg.t_base - div_quo[15:0])
                                           : (s_reg.t_base + div_quo[15:0]);
                  s_next.div_num   = FULL_SCALE_Q8;
                  s_next.div_den   = sdrl_tsafe(t_eff);
                  s_next.div_start = 1'b1;
                  s_next.phase     = PH_STEP;
               end
            end
            PH_STEP: begin
               if (div_done) begin
                  s_next.div_num = div_quo;
                  s_next.phase   = PH_APPLY;
               end
            end
            PH_APPLY: begin
               // Progressive shape scales the step by the segment slope
               if (cur_int < BRK_1) begin
                  smax = SLOPE_SEG0;
               end else if (cur_int < BRK_2) begin
                  smax = SLOPE_SEG1;
               end else if (cur_int < BRK_3) begin
                  smax = SLOPE_SEG2;
               end else begin
                  smax = SLOPE_SEG3;
               end
               slope_i = SLOPE_UNITY +
                         (((smax - SLOPE_UNITY) * int'(s_reg.shape) * TENTH_Q8) >>> 8);
               step_i  = (int'(s_reg.div_num[17:0]) * slope_i) >>> 8;
               step    = (step_i < 1) ? 18'h00001 : 18'(step_i);
               // Clamp to the target so the ramp never overshoots
               if (s_reg.going_up) begin
                  if ((s_reg.tgt_mag - s_reg.cur_mag) <= step) begin
                     s_next.cur_mag = s_reg.tgt_mag;
                  end else begin
                     s_next.cur_mag = s_reg.cur_mag + step;
                  end
               end else begin
                  if ((s_reg.cur_mag - s_reg.tgt_mag) <= step) begin
                     s_next.cur_mag = s_reg.tgt_mag;
                  end else begin
                     s_next.cur_mag = s_reg.cur_mag - step;
                  end
               end
               s_next.phase = PH_IDLE;
            end
            default: begin
               s_next.phase = PH_IDLE;
            end
         endcase
      end

      // Signed set-point handed to the spool loop
      s_next.out_flow = s_next.cur_neg ? (16'h0000 - {6'h00, s_next.cur_mag[17:8]})
                                       : {6'h00, s_next.cur_mag[17:8]};
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_reg        <= '0;
         s_reg.wait_r <= 1'b1;
         s_reg.cfg    <= CFG_RESET;
         s_reg.phase  <= PH_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign avs_readdata_o      = s_reg.rdata;
   assign avs_waitrequest_o   = s_reg.wait_r;
   assign limited_port_flow_o = s_reg.out_flow;
   assign abort_active_o      = s_reg.abort_act;

endmodule : sdrl_ramp_limiter

// *** sdrl_spool_model.sv ***
module sdrl_spool_model #(
   parameter int SLEW = 4
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] setpoint_i,
   output logic      [15:0] spool_pos_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Finite slew of SLEW per clock; the spool snaps to its set-point once within 4 of it
   logic signed [15:0] sp;
   logic signed [15:0] pos;
   assign sp  = setpoint_i;
   assign pos = spool_pos_o;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spool_pos_o <= 16'h0000;
      end else if (pos < sp - 16'sd4) begin
         spool_pos_o <= 16'(pos + 16'(SLEW));
      end else if (pos > sp + 16'sd4) begin
         spool_pos_o <= 16'(pos - 16'(SLEW));
      end else begin
         spool_pos_o <= setpoint_i;
      end
   end
endmodule : sdrl_spool_model

// *** sdrl_ramp_limiter_sva.sv ***
module sdrl_ramp_limiter_sva
   import sdrl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC_DEF
) (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [15:0] requested_port_flow_i,
   input wire logic [15:0] vehicle_speed_i,
   input wire logic [15:0] limited_port_flow_o,
   input wire logic        abort_active_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] meth_q, athr_q, lim_d;
   logic [31:0] gap;
   logic        armed, off, rmode, athr_off, wr_take, req_any;
   assign wr_take  = avs_write_i & avs_waitrequest_o;
   assign req_any  = avs_read_i | avs_write_i;
   assign rmode    = (meth_q == METHOD_FIXED) | (meth_q == METHOD_SPEED);
   assign off      = ~rmode;
   assign athr_off = (athr_q == FLOW_MAX);
   function automatic logic [15:0] merge(input logic [15:0] o);
      merge = o;
      if (avs_byteenable_i[0]) merge[7:0] = avs_writedata_i[7:0];
      if (avs_byteenable_i[1]) merge[15:8] = avs_writedata_i[15:8];
   endfunction : merge
   // Gap since last output move; a method write disarms it, first ramp tick may come early
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meth_q <= 16'h0000;
         athr_q <= 16'h0000;
         lim_d  <= 16'h0000;
         gap    <= 32'h0;
         armed  <= 1'b0;
      end else begin
         lim_d <= limited_port_flow_o;
         gap   <= (limited_port_flow_o != lim_d) ? 32'h0 : gap + 32'h1;
         if (limited_port_flow_o != lim_d) armed <= 1'b1;
         if (wr_take && avs_address_i == ADDR_METHOD) begin
            meth_q <= merge(meth_q);
            armed  <= 1'b0;
         end
         if (wr_take && avs_address_i == ADDR_ABORT_THR) athr_q <= merge(athr_q);
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   chk_wait_answer: assert property (req_any && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus request not answered after one wait cycle");
   chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   chk_wait_cause: assert property (!avs_waitrequest_o |-> $past(req_any))
      else $error("waitrequest low without a request");
   chk_unmapped_zero: assert property (
      avs_read_i && avs_waitrequest_o && avs_address_i > ADDR_RAMP_STAT
      |=> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
   chk_upper_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   chk_bypass_follow: assert property (
      $past(off) |-> limited_port_flow_o == $past(requested_port_flow_i))
      else $error("bypass output differs from request");
   chk_tick_spacing: assert property (
      rmode && armed && (limited_port_flow_o != lim_d) |-> gap >= TICK_CYCLES - 1)
      else $error("ramp output moved twice within one tick");
   chk_abort_disable: assert property (
      athr_off && $past(athr_off) |-> !$rose(abort_active_o))
      else $error("abort raised with abort disabled");
   chk_abort_mode: assert property ($rose(abort_active_o) |-> rmode)
      else $error("abort raised outside ramp mode");
   cov_abort: cover property ($rose(abort_active_o));
   cov_read: cover property (avs_read_i && !avs_waitrequest_o);
   cov_ramp_move: cover property (rmode && armed && (limited_port_flow_o != lim_d));
endmodule : sdrl_ramp_limiter_sva
bind sdrl_ramp_limiter sdrl_ramp_limiter_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sdrl_ramp_limiter_sva (
   .mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
   .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .requested_port_flow_i,
   .vehicle_speed_i, .limited_port_flow_o, .abort_active_o);

// *** sdrl_ramp_limiter_tb_top.sv ***
module sdrl_ramp_limiter_tb_top import sdrl_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 100;
   logic        mclk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, wait_o, abort;
   logic [3:0]  addr = 4'h0, be = 4'hf;
   logic [31:0] wdat = 32'h0, rdat;
   logic [15:0] req = 16'h0, spd = 16'h0, lim, spool;
   logic [15:0] rv [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h015e, 16'h03e8,
                           16'h0064, 16'h0000, 16'h0001, 16'h00c8, 16'h015e, 16'h01f4};
   int          err_count = 0, n_checks = 0, cyc = 0;
   int          up_st, slow_st, fast_st, fthr, cur = 0;
   int          tl [6] = '{2, 4, 5, 8, 10, 20};
   int          at [4] = '{0, 300, 300, 1000};
   int          ar [4] = '{-5, -200, -400, -1000};
   sdrl_ramp_limiter #(.TICK_CYCLES(TICK)) i_sdrl_ramp_limiter (
      .mclk_i, .rst_n_i, .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_o), .requested_port_flow_i(req), .vehicle_speed_i(spd),
      .limited_port_flow_o(lim), .abort_active_o(abort));
   sdrl_spool_model i_sdrl_spool_model (.mclk_i, .rst_n_i, .setpoint_i(lim), .spool_pos_o(spool));
   initial forever #2 mclk_i = ~mclk_i;
   task automatic close_out;
      if (err_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         err_count++;
         $display("MISMATCH run time exp done got hang");
         close_out();
      end
   end
   task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk_val
   task automatic chk_flow(input string nm, input int e, input logic [15:0] g);
      chk_val(nm, {16'h0, 16'(e)}, {16'h0, g});
   endtask : chk_flow
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_val(nm, {31'h0, e}, {31'h0, g});
   endtask : chk_bit
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk_i);
      addr <= a;
      wdat <= d;
      be <= b;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wait_o !== 1'b0);
      q = rdat;
      chk_val("bus wait", 32'h2, 32'(n));
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus
   task automatic wreg(input logic [3:0] a, input int d);
      logic [31:0] q;
      bus(1'b1, a, 32'(d), 4'hf, q);
   endtask : wreg
   task automatic rreg(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk_val($sformatf("reg %0d", a), e, q);
   endtask : rreg
   function automatic int nxt(input int c0, input int tgt);
      int s, c, t, st;
      s = (c0 < 0 || tgt < 0) ? -1 : 1;
      c = c0 * s;
      t = tgt * s;
      st = (t > c) ? up_st : ((c > fthr) ? fast_st : slow_st);
      c = (t > c) ? ((c + st > t) ? t : c + st) : ((c - st < t) ? t : c - st);
      return c * s;
   endfunction : nxt
   task automatic wait_chg;
      logic [15:0] o;
      int n;
      o = lim;
      n = 0;
      while (lim === o && n < 3 * TICK) begin
         @(posedge mclk_i);
         n++;
      end
   endtask : wait_chg
   task automatic next_upd(input int e, input string nm);
      wait_chg();
      chk_flow(nm, e, lim);
      cur = e;
   endtask : next_upd
   task automatic ramp_to(input int tgt);
      req <= 16'(tgt);
      while (cur != tgt) next_upd(nxt(cur, tgt), "ramp step");
   endtask : ramp_to
   task automatic to_zero;
      int n;
      req <= 16'h0;
      n = 0;
      while (lim !== 16'h0 && n < 40 * TICK) begin
         @(posedge mclk_i);
         n++;
      end
      cur = 0;
      chk_flow("settle", 0, lim);
   endtask : to_zero
   task automatic cfg(input int m, input int tu, input int ts, input int tf, input int thr);
      up_st = 1000 / tu;
      slow_st = 1000 / ts;
      fast_st = 1000 / tf;
      fthr = thr;
      wreg(ADDR_UP_SHAPE, 0);
      wreg(ADDR_DN_SHAPE, 0);
      wreg(ADDR_UP_TIME, tu);
      wreg(ADDR_SLOW_TIME, ts);
      wreg(ADDR_FAST_TIME, tf);
      wreg(ADDR_FAST_THR, thr);
      wreg(ADDR_METHOD, m);
   endtask : cfg
   initial begin
      logic [31:0] d;
      logic [15:0] e;
      logic [3:0]  b;
      int          v;
      void'($urandom(32'h39a3));
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      foreach (rv[i]) rreg(4'(i), {16'h0, rv[i]});
      wreg(4'hf, 16'h1234);
      rreg(4'hf, 32'h0);
      wreg(ADDR_FLOW_STAT, 55);
      rreg(ADDR_FLOW_STAT, 32'h0);
      for (int i = 0; i < 12; i++) begin
         d = $urandom;
         b = 4'($urandom);
         e = rv[i];
         if (b[0]) e[7:0] = d[7:0];
         if (b[1]) e[15:8] = d[15:8];
         bus(1'b1, 4'(i), d, b, d);
         rreg(4'(i), {16'h0, e});
      end
      cfg(0, 1, 20, 1, 1000);
      repeat (40) begin
         v = $urandom_range(2000) - 1000;
         req <= 16'(v);
         @(posedge mclk_i);
         @(posedge mclk_i);
         chk_flow("bypass", v, lim);
      end
      rreg(ADDR_FLOW_STAT, {16'h0, 16'(v)});
      to_zero();
      for (int k = 0; k < 4; k++) begin
         cfg(1, tl[$urandom_range(5)], tl[$urandom_range(5)], 1, 1000);
         v = $urandom_range(1000, 1);
         ramp_to(k[0] ? -v : v);
         ramp_to(0);
      end
      cfg(1, 1, 20, 4, 500);
      ramp_to(1000);
      ramp_to(0);
      ramp_to(-1000);
      ramp_to(0);
      cfg(1, 1, 20, 4, 1000);
      wreg(ADDR_ABORT_TIM, 2);
      for (int i = 0; i < 4; i++) begin
         wreg(ADDR_ABORT_THR, at[i]);
         ramp_to(1000);
         req <= 16'h0;
         next_upd(950, "slow step");
         req <= 16'(ar[i]);
         next_upd((i % 2 == 0) ? 450 : 900, "abort step");
         chk_bit("abort flag", i % 2 == 0, abort);
         rreg(ADDR_RAMP_STAT, {31'h0, i % 2 == 0});
         to_zero();
         repeat (TICK) @(posedge mclk_i);
         chk_bit("abort clear", 1'b0, abort);
      end
      cfg(1, 10, 20, 4, 1000);
      wreg(ADDR_UP_SHAPE, 10);
      req <= 16'h03e8;
      wait_chg();
      e = lim;
      chk_bit("up shape", 1'b1, e != 16'h0 && e < 16'h0032);
      wreg(ADDR_DN_SHAPE, 10);
      req <= 16'h0;
      wait_chg();
      chk_bit("down shape", 1'b1, lim != 16'h0 && lim < e);
      to_zero();
      cfg(2, 10, 20, 4, 1000);
      wreg(ADDR_UP_TIME_HS, 5);
      wreg(ADDR_SLOW_TM_HS, 20);
      wreg(ADDR_SPEED_LIM, 500);
      for (int i = 0; i < 2; i++) begin
         spd <= i ? 16'h0258 : 16'h0000;
         req <= 16'h03e8;
         next_upd(i ? 200 : 100, "speed step");
         to_zero();
      end
      repeat (3 * TICK) @(posedge mclk_i);
      chk_flow("spool", 0, spool);
      close_out();
   end
endmodule : sdrl_ramp_limiter_tb_top
